// [common/adc_ctl_pkg.sv]
package adc_ctl_pkg;
  // calibration mode field codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_INT_ZERO = 3'h4;
  localparam logic [2:0] MODE_INT_FULL = 3'h5;
  localparam logic [2:0] MODE_SYS_ZERO = 3'h6;
  localparam logic [2:0] MODE_SYS_FULL = 3'h7;
  // data widths
  localparam int WIDE_BITS = 24;
  localparam int NARROW_BITS = 16;
  // reset values
  localparam logic [23:0] OFFSET_RESET = 24'h800000;
  localparam logic [23:0] GAIN_RESET = 24'h555555;
  localparam logic [2:0] RANGE_RESET = 3'h7;
  localparam logic [2:0] RANGE_GAIN_ONE = 3'h7;
  // midscale code for bipolar zero
  localparam logic [23:0] MIDSCALE_CODE = 24'h800000;
  // power-up wait
  localparam int CLK_HZ = 10_000_000;
  localparam int POWERUP_US = 500;
  localparam int POWERUP_CYC = (CLK_HZ / 1_000_000) * POWERUP_US;
  // input selection source
  typedef struct packed {
    logic [3:0] chan;    // 0..9 selects input 1..10
    logic pseudo;        // 1 = pseudo-differential
  } chan_sel_t;
  // routed input pair
  typedef struct packed {
    logic [3:0] pos;     // positive input index 0..9
    logic [3:0] neg;     // negative input index, 4'hf = common pin
    logic use_ref;       // reference routed to input
    logic short_in;      // inputs shorted for internal zero cal
  } route_t;
endpackage

// [src/adc_ctl.sv]
`timescale 1ns/1ps
module adc_ctl
  import adc_ctl_pkg::*;
#(
  parameter int N_BITS = WIDE_BITS,
  parameter int POWERUP_CYCLES = POWERUP_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // mode field write
  input wire logic mode_wr,
  input wire logic [2:0] cal_mode_field,
  input wire logic done_clr,
  // configuration
  input wire logic [2:0] gain_range_bits,
  input wire logic bipolar,
  input wire chan_sel_t chan_sel,
  input wire logic [3:0] excitation_control_reg,
  input wire logic power_down,
  // modulator side
  input wire logic [N_BITS-1:0] raw_result,
  input wire logic raw_valid,
  input wire logic ref_missing_pin,
  // aux converter side
  input wire logic [N_BITS-1:0] aux_raw,
  input wire logic aux_valid,
  // routing and gain outputs
  output route_t route_ff,
  output logic [7:0] gain_ff,
  output logic [1:0] exc_a_ff,
  output logic [1:0] exc_b_ff,
  // results and status
  output logic [N_BITS-1:0] result_ff,
  output logic [N_BITS-1:0] aux_result_ff,
  output logic [N_BITS-1:0] offset_coef_ff,
  output logic [N_BITS-1:0] gain_coef_ff,
  output logic primary_done_flag,
  output logic cal_busy_ff,
  output logic cal_err_ff,
  output logic ref_missing_flag,
  output logic power_ok_ff
);

  // calibration sequencer states
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_ZERO = 3'b010,
    ST_FULL = 3'b100
  } cal_st_t;

  cal_st_t st_ff; // sequencer state
  logic is_internal_ff; // running cal is internal
  logic ref_s1_ff; // synchroniser stage one
  logic ref_s2_ff; // synchronised reference missing
  logic done_ff; // ready flag storage
  logic [$clog2(POWERUP_CYCLES+1)-1:0] pwr_cnt_ff; // power-up wait counter

  // two-flop synchroniser for the reference detector pin
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ref_s1_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
    end else begin
      ref_s1_ff <= ref_missing_pin;
      ref_s2_ff <= ref_s1_ff;
    end
  end

  // decode of a mode write
  wire start_zero = mode_wr && (cal_mode_field == MODE_SYS_ZERO ||
                                cal_mode_field == MODE_INT_ZERO);
  wire start_full = mode_wr && (cal_mode_field == MODE_SYS_FULL ||
                                cal_mode_field == MODE_INT_FULL);
  wire start_int = (cal_mode_field == MODE_INT_ZERO) ||
                   (cal_mode_field == MODE_INT_FULL);
  wire cal_active = (st_ff != ST_RUN);
  wire cal_abort = cal_active && ref_s2_ff;
  // completion of a calibration conversion, gated by the ready flag
  wire cal_sample = cal_active && raw_valid && !ref_s2_ff && !done_ff;
  wire conv_sample = !cal_active && raw_valid && !done_ff;

  // gain stage: each step down in range doubles the gain, range 7 is gain one
  wire [2:0] shift_amt = 3'(RANGE_GAIN_ONE - gain_range_bits);
  wire [7:0] range_gain = 8'(8'h01 << shift_amt);
  wire force_unity = (st_ff == ST_FULL) && is_internal_ff;

  // offset-corrected result; bipolar zero lands at midscale
  wire [N_BITS-1:0] mid = N_BITS'(MIDSCALE_CODE >> (WIDE_BITS - N_BITS));
  wire [N_BITS:0] diff = {1'b0, raw_result} - {1'b0, offset_coef_ff};
  wire [N_BITS:0] uni_sum = diff;
  wire [N_BITS+1:0] bip_sum = {diff[N_BITS], diff} + {2'b00, mid};
  // clamp out-of-range to all zeros or all ones
  wire uni_low = diff[N_BITS];
  wire bip_low = bip_sum[N_BITS+1];
  wire bip_high = !bip_sum[N_BITS+1] && bip_sum[N_BITS];
  wire [N_BITS-1:0] uni_code = uni_low ? '0 : uni_sum[N_BITS-1:0];
  wire [N_BITS-1:0] bip_code = bip_low ? '0 :
                               bip_high ? '1 : bip_sum[N_BITS-1:0];
  // a missing reference clamps the conversion result to all ones; aux_result_ff is not clamped
  wire [N_BITS-1:0] conv_code = ref_s2_ff ? '1 : (bipolar ? bip_code : uni_code);
  // auxiliary: no gain stage, raw already referred to full scale
  wire [N_BITS-1:0] aux_code = bipolar ? (aux_raw ^ mid) : aux_raw;

  // input pair routing
  wire [3:0] diff_pos = {chan_sel.chan[3:1], 1'b0};
  wire [3:0] diff_neg = {chan_sel.chan[3:1], 1'b1};
  wire [3:0] nxt_pos = chan_sel.pseudo ? chan_sel.chan : diff_pos;
  wire [3:0] nxt_neg = chan_sel.pseudo ? 4'hf : diff_neg;

  // current source routing: bits[1:0] source one, bits[3:2] source two
  // each pair: 01 = pin a, 10 = pin b, else off
  wire src1_a = excitation_control_reg[1:0] == 2'h1;
  wire src1_b = excitation_control_reg[1:0] == 2'h2;
  wire src2_a = excitation_control_reg[3:2] == 2'h1;
  wire src2_b = excitation_control_reg[3:2] == 2'h2;
  // count of 200 uA units on each pin, 2 means 400 uA
  wire [1:0] nxt_exc_a = 2'(src1_a) + 2'(src2_a);
  wire [1:0] nxt_exc_b = 2'(src1_b) + 2'(src2_b);

  // calibration sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_ff <= ST_RUN;
      is_internal_ff <= 1'b0;
    end else if (cal_abort || cal_sample) begin
      st_ff <= ST_RUN;
    end else if (start_zero) begin
      st_ff <= ST_ZERO;
      is_internal_ff <= start_int;
    end else if (start_full) begin
      st_ff <= ST_FULL;
      is_internal_ff <= start_int;
    end
  end

  // coefficient capture, skipped on abort
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      offset_coef_ff <= N_BITS'(OFFSET_RESET >> (WIDE_BITS - N_BITS));
      gain_coef_ff <= N_BITS'(GAIN_RESET >> (WIDE_BITS - N_BITS));
    end else if (cal_sample && st_ff == ST_ZERO) begin
      // raw zero reading kept as is; bipolar adds midscale after subtraction
      offset_coef_ff <= raw_result;
    end else if (cal_sample && st_ff == ST_FULL) begin
      gain_coef_ff <= raw_result;
    end
  end

  // ready flag: hardware set wins over software clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      done_ff <= 1'b0;
    end else if (cal_sample || conv_sample) begin
      done_ff <= 1'b1;
    end else if (done_clr || mode_wr) begin
      done_ff <= 1'b0;
    end
  end

  // results, error and status
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      result_ff <= '0;
      aux_result_ff <= '0;
      cal_err_ff <= 1'b0;
      cal_busy_ff <= 1'b0;
      ref_missing_flag <= 1'b0;
      primary_done_flag <= 1'b0;
    end else begin
      if (conv_sample) begin
        result_ff <= conv_code;
      end
      if (aux_valid) begin
        aux_result_ff <= aux_code;
      end
      // error sticks until the next mode write
      if (cal_abort) begin
        cal_err_ff <= 1'b1;
      end else if (mode_wr) begin
        cal_err_ff <= 1'b0;
      end
      cal_busy_ff <= (st_ff != ST_RUN) && !cal_abort && !cal_sample;
      ref_missing_flag <= ref_s2_ff;
      primary_done_flag <= done_ff;
    end
  end

  // routing and gain stage drive
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      route_ff <= '0;
      gain_ff <= 8'h01;
      exc_a_ff <= 2'h0;
      exc_b_ff <= 2'h0;
    end else begin
      route_ff.pos <= nxt_pos;
      route_ff.neg <= nxt_neg;
      route_ff.use_ref <= force_unity;
      route_ff.short_in <= (st_ff == ST_ZERO) && is_internal_ff;
      gain_ff <= force_unity ? 8'h01 : range_gain;
      exc_a_ff <= nxt_exc_a;
      exc_b_ff <= nxt_exc_b;
    end
  end

  // power-up wait; informs software, results are not blocked
  always_ff @(posedge sys_clk) begin
    if (!rst_b || power_down) begin
      pwr_cnt_ff <= '0;
      power_ok_ff <= 1'b0;
    end else if (pwr_cnt_ff != ($bits(pwr_cnt_ff))'(POWERUP_CYCLES)) begin
      pwr_cnt_ff <= pwr_cnt_ff + 1'b1;
      power_ok_ff <= 1'b0;
    end else begin
      power_ok_ff <= 1'b1;
    end
  end

  // checks
  done_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cal_sample || conv_sample) |=> ##1 primary_done_flag)
    else $error("ready flag not set after completion");
  abort_no_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cal_abort |=> $stable(offset_coef_ff) && $stable(gain_coef_ff) && st_ff == ST_RUN)
    else $error("coefficients written on abort");
  unity_gain_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    force_unity |=> gain_ff == 8'h01 && route_ff.use_ref)
    else $error("internal full cal not at gain one");
  range_gain_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!force_unity && gain_range_bits == 3'h0) |=> gain_ff == 8'h80)
    else $error("range zero not gain 128");
  sys_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (mode_wr && cal_mode_field == MODE_SYS_ZERO && !cal_active) |=>
      st_ff == ST_ZERO && !is_internal_ff)
    else $error("system zero cal not started");
  sys_full_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (mode_wr && cal_mode_field == MODE_SYS_FULL && !cal_active) |=> st_ff == ST_FULL)
    else $error("system full cal not started");
  pair_route_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !chan_sel.pseudo |=> route_ff.neg == route_ff.pos + 4'h1)
    else $error("differential pair wrong");
  pseudo_route_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    chan_sel.pseudo |=> route_ff.neg == 4'hf)
    else $error("pseudo mode not on common pin");
  exc_combine_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    excitation_control_reg == 4'h5 |=> exc_a_ff == 2'h2 && exc_b_ff == 2'h0)
    else $error("combined source not on pin a");
  uni_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (conv_sample && !bipolar && !ref_s2_ff && raw_result == offset_coef_ff) |=>
      result_ff == '0)
    else $error("unipolar zero not all zeros");
  bip_mid_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (conv_sample && bipolar && !ref_s2_ff && raw_result == offset_coef_ff) |=>
      result_ff == mid)
    else $error("bipolar zero not midscale");

endmodule

// [tb/front_model.sv]
`timescale 1ns/1ps
// stand-in for the modulator: one reading per request, prompt or slow
module front_model #(parameter int W = 24) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // request from the bench
  input wire logic go,
  input wire logic slow,
  input wire logic [W-1:0] level,
  // modulator word
  output logic [W-1:0] raw_result,
  output logic raw_valid
);
  logic [3:0] cnt_ff; // cycles left until the word is ready
  logic [W-1:0] hold_ff; // reading asked for
  // the word means something only in its valid cycle, so it toggles otherwise
  always_ff @(posedge sys_clk) begin
    raw_valid <= 1'b0;
    raw_result <= ~raw_result;
    if (!rst_b) begin
      cnt_ff <= 4'h0;
      raw_result <= '0;
    end else if (go) begin
      cnt_ff <= slow ? 4'h8 : 4'h1;
      hold_ff <= level;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
      // last count: present the reading for one cycle
      if (cnt_ff == 4'h1) begin
        raw_valid <= 1'b1;
        raw_result <= hold_ff;
      end
    end
  end
endmodule

// [tb/test_adc_calibration_and_output_coding.sv]
`timescale 1ns/1ps
module test_adc_calibration_and_output_coding;
  import adc_ctl_pkg::*;
  // design inputs, all defined at time zero except raw_result and raw_valid, driven by the front model
  logic sys_clk = 1'b0, rst_b = 1'b0, mode_wr = 1'b0, done_clr = 1'b0, bipolar = 1'b0;
  logic [2:0] cal_mode_field = 3'h0, gain_range_bits = 3'h7;
  chan_sel_t chan_sel = '0;
  logic [3:0] excitation_control_reg = 4'h0;
  logic power_down = 1'b0, ref_missing_pin = 1'b0, aux_valid = 1'b0, go = 1'b0, slow = 1'b1;
  logic [23:0] aux_raw = 24'h0, level = 24'h0, raw_result;
  logic raw_valid;
  // design outputs
  route_t route_ff, snap_route;
  logic [7:0] gain_ff, snap_gain;
  logic [1:0] exc_a_ff, exc_b_ff;
  logic [23:0] result_ff, aux_result_ff, offset_coef_ff, gain_coef_ff;
  logic primary_done_flag, cal_busy_ff, cal_err_ff, ref_missing_flag, power_ok_ff, snap_busy;
  int failures = 0, n_checks = 0;
  localparam logic [23:0] ZERO_RD = 24'h100000; // raw zero reading used for offset
  localparam int TB_PWR = 20; // short power-up wait for simulation
  int pw_cyc; // cycles seen until power ok
  // expected conversions: polarity, raw word, code
  logic tb_bip [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [23:0] tb_raw [6] = '{24'h101234, 24'h0fffff, 24'h100000, 24'h100000, 24'hffffff,
                              24'h000000};
  logic [23:0] tb_exp [6] = '{24'h001234, 24'h000000, 24'h000000, 24'h800000, 24'hffffff,
                              24'h700000};

  adc_ctl #(.N_BITS(24), .POWERUP_CYCLES(TB_PWR)) DUT (.sys_clk(sys_clk), .rst_b(rst_b),
    .mode_wr(mode_wr), .cal_mode_field(cal_mode_field), .done_clr(done_clr),
    .gain_range_bits(gain_range_bits), .bipolar(bipolar), .chan_sel(chan_sel),
    .excitation_control_reg(excitation_control_reg), .power_down(power_down),
    .raw_result(raw_result), .raw_valid(raw_valid), .ref_missing_pin(ref_missing_pin),
    .aux_raw(aux_raw), .aux_valid(aux_valid), .route_ff(route_ff), .gain_ff(gain_ff),
    .exc_a_ff(exc_a_ff), .exc_b_ff(exc_b_ff), .result_ff(result_ff),
    .aux_result_ff(aux_result_ff), .offset_coef_ff(offset_coef_ff),
    .gain_coef_ff(gain_coef_ff), .primary_done_flag(primary_done_flag),
    .cal_busy_ff(cal_busy_ff), .cal_err_ff(cal_err_ff),
    .ref_missing_flag(ref_missing_flag), .power_ok_ff(power_ok_ff));
  front_model #(.W(24)) u_front (.sys_clk(sys_clk), .rst_b(rst_b), .go(go), .slow(slow),
    .level(level), .raw_result(raw_result), .raw_valid(raw_valid));

  // 100 ns clock
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // let registered outputs land, then sample mid-cycle
  task automatic settle();
    tick(2);
    @(negedge sys_clk);
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // write the mode field, have the front end deliver one word, wait for ready
  task automatic run(input logic [2:0] code, input logic [23:0] lvl, input logic want);
    @(posedge sys_clk);
    mode_wr <= 1'b1;
    cal_mode_field <= code;
    @(posedge sys_clk);
    mode_wr <= 1'b0;
    go <= 1'b1;
    level <= lvl;
    @(posedge sys_clk);
    go <= 1'b0;
    tick(1);
    @(negedge sys_clk);
    snap_route = route_ff;
    snap_gain = gain_ff;
    snap_busy = cal_busy_ff;
    for (int k = 0; k < 40 && primary_done_flag !== 1'b1; k++) @(negedge sys_clk);
    chk(primary_done_flag, want, "ready flag");
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    tick(3000);
    failures++;
    final_report();
  end

  initial begin
    tick(4);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk(offset_coef_ff, OFFSET_RESET, "offset reset");
    chk(gain_ff, 24'd1, "gain reset");
    chk(power_ok_ff, 24'd0, "power early");
    // counter runs 0..TB_PWR, the flag follows one edge later
    for (pw_cyc = 0; pw_cyc < 40 && power_ok_ff !== 1'b1; pw_cyc++) @(negedge sys_clk);
    chk(power_ok_ff, 24'd1, "power ok");
    chk(24'(pw_cyc), 24'(TB_PWR + 1), "power wait");
    // every gain range halves the gain from 128 down to 1
    for (int r = 0; r < 8; r++) begin
      @(posedge sys_clk);
      gain_range_bits <= r[2:0];
      settle();
      chk(gain_ff, 24'd128 >> r, "gain");
    end
    // input pairing: even index pairs with the next, pseudo uses the common pin
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      chan_sel <= chan_sel_t'({i[4:1], i[0]});
      settle();
      // differential: any index of a pair selects that pair
      chk(route_ff.pos, i[0] ? 24'(i >> 1) : 24'((i >> 2) * 2), "pos");
      chk(route_ff.neg, i[0] ? 24'hf : 24'((i >> 2) * 2 + 1), "neg");
    end
    // every current source setting
    for (int e = 0; e < 16; e++) begin
      @(posedge sys_clk);
      excitation_control_reg <= e[3:0];
      settle();
      chk(exc_a_ff, (e[1:0] == 2'h1) + (e[3:2] == 2'h1), "exc a");
      chk(exc_b_ff, (e[1:0] == 2'h2) + (e[3:2] == 2'h2), "exc b");
    end
    @(posedge sys_clk);
    gain_range_bits <= 3'h0; // calibrate at the working range
    run(MODE_SYS_ZERO, ZERO_RD, 1'b1);
    chk(snap_busy, 24'd1, "busy");
    chk(offset_coef_ff, ZERO_RD, "offset coef");
    run(MODE_SYS_FULL, 24'hc00000, 1'b1);
    chk(gain_coef_ff, 24'hc00000, "gain coef");
    run(MODE_INT_FULL, 24'hd00000, 1'b1);
    chk(snap_route.use_ref, 24'd1, "ref routed");
    chk(snap_gain, 24'd1, "unity gain");
    chk(gain_coef_ff, 24'hd00000, "int gain coef");
    run(MODE_INT_ZERO, ZERO_RD, 1'b1);
    chk(snap_route.short_in, 24'd1, "shorted");
    @(posedge sys_clk);
    done_clr <= 1'b1;
    @(posedge sys_clk);
    done_clr <= 1'b0;
    // the flag trails the internal ready bit by one edge
    settle();
    chk(primary_done_flag, 24'd0, "ready cleared");
    slow <= 1'b0;
    for (int j = 0; j < 6; j++) begin
      @(posedge sys_clk);
      bipolar <= tb_bip[j];
      run(3'h2, tb_raw[j], 1'b1);
      chk(result_ff, tb_exp[j], "code");
    end
    // a word arriving while ready is still set must be dropped
    @(posedge sys_clk);
    go <= 1'b1;
    level <= 24'h123456;
    @(posedge sys_clk);
    go <= 1'b0;
    settle();
    chk(result_ff, 24'h700000, "blocked");
    for (int b = 0; b < 2; b++) begin
      @(posedge sys_clk);
      bipolar <= b[0];
      aux_raw <= 24'h3a5c71;
      aux_valid <= 1'b1;
      @(posedge sys_clk);
      aux_valid <= 1'b0;
      @(negedge sys_clk);
      chk(aux_result_ff, b ? 24'hba5c71 : 24'h3a5c71, "aux");
    end
    // reference lost: calibration stops and coefficients stay
    slow <= 1'b1;
    @(posedge sys_clk);
    ref_missing_pin <= 1'b1;
    // the word after the abort lands as a clamped conversion and sets ready
    run(MODE_SYS_ZERO, 24'h222222, 1'b1);
    chk(snap_busy, 24'd0, "abort busy");
    chk(result_ff, 24'hffffff, "clamped");
    chk(offset_coef_ff, ZERO_RD, "no write");
    chk({ref_missing_flag, cal_err_ff}, 24'd3, "abort flags");
    @(posedge sys_clk);
    ref_missing_pin <= 1'b0;
    tick(4);
    run(MODE_SYS_ZERO, ZERO_RD, 1'b1);
    chk(cal_err_ff, 24'd0, "err cleared");
    @(posedge sys_clk);
    power_down <= 1'b1;
    settle();
    chk(power_ok_ff, 24'd0, "power down");
    final_report();
  end
endmodule
